// >>> inc/adc_seq_pkg.sv
// constants and types of the two-converter sequencer
// Summary of operation
// - two 10-bit converters, 16 and 8 channels
// - programmable sample and per-bit conversion times
// - 8-bit mode converts fewer bit steps
// - sync mode samples both converters together for channels 0 to 15
// - external multiplexer select advances per conversion
// - sources start by trigger inputs or software
// - parallel source converts lowest channel first
// - queue converts in software entry order
// - inserted channel converts, sequence then resumes
// - highest priority pending source starts next
// - limit check and result accumulation
// - eight result registers per converter, optionally chained FIFO
// - wait-for-read stalls overwrite of unread result
// - transfer request pulse per stored result
// - per-pin digital input disable
// - unused pins readable as digital inputs
// - power down whenever no conversion runs
// - individually enabled event requests
package adc_seq_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TIMING = 8'h04;
  localparam logic [7:0] ADDR_PRIO = 8'h08;
  localparam logic [7:0] ADDR_PAR_SEL = 8'h0C;
  localparam logic [7:0] ADDR_START = 8'h10;
  localparam logic [7:0] ADDR_QUEUE = 8'h14;
  localparam logic [7:0] ADDR_INSERT = 8'h18;
  localparam logic [7:0] ADDR_LIMITS = 8'h1C;
  localparam logic [7:0] ADDR_WFR = 8'h20;
  localparam logic [7:0] ADDR_EVT_EN = 8'h24;
  localparam logic [7:0] ADDR_DIGIN_OFF = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2C;
  localparam logic [7:0] ADDR_PIN = 8'h30;
  localparam logic [1:0] RES_REGION = 2'h1;
  localparam int CTRL_MODE8 = 0;
  localparam int CTRL_SYNC = 1;
  localparam int CTRL_CHAIN = 2;
  localparam int CTRL_ACCUM = 3;
  localparam int CTRL_APD = 4;
  localparam int CTRL_EMUX_EN = 5;
  localparam int CTRL_EMUX_LEN = 6;
  localparam int PRIO_PAR = 0;
  localparam int PRIO_QUE = 2;
  localparam int PRIO_INS = 4;
  localparam int TRIG_PAR = 8;
  localparam int TRIG_QUE = 10;
  localparam int TRIG_PAR_EN = 12;
  localparam int TRIG_QUE_EN = 13;
  localparam int START_PAR = 0;
  localparam int START_QUE = 1;
  localparam int TIM_SAMPLE = 0;
  localparam int TIM_BIT = 8;
  localparam int LIM_LO = 0;
  localparam int LIM_HI = 16;
  localparam int EVT_DONE = 0;
  localparam int EVT_LIMIT = 1;
  localparam int EVT_SEQ = 2;
  localparam logic [2:0] QUEUE_DEPTH = 3'h4;
  localparam logic [3:0] BIT_TOP = 4'h9;
  localparam logic [3:0] BIT_LAST10 = 4'h0;
  localparam logic [3:0] BIT_LAST8 = 4'h2;
  localparam logic [31:0] RST_TIMING = 32'h0000_0303;
  localparam logic [31:0] RST_LIMITS = 32'h03FF_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SRC_PAR = 2'h0;
  localparam logic [1:0] SRC_QUE = 2'h1;
  localparam logic [1:0] SRC_INS = 2'h2;
  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONV} state_type;
endpackage

// >>> hdl/sar_adc_sequencer.sv
// two-converter sequencer with AXI4-Lite registers
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer (
  // clock and reset
  input wire logic CLK_I,
  input wire logic SRST_I,
  // AXI4-Lite slave
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // triggers, comparators, pins
  input wire logic [3:0] TRIG_I,
  input wire logic [1:0] CMP_I,
  input wire logic [23:0] PIN_I,
  // analog front end control
  output logic [1:0] SAMPLE_O,
  output logic [3:0] CH0_SEL_O,
  output logic [2:0] CH1_SEL_O,
  output logic [9:0] DAC0_O,
  output logic [9:0] DAC1_O,
  output logic [2:0] EMUX_O,
  output logic [1:0] PWRDN_O,
  output logic [15:0] PORT_FIVE_DIGIN_OFF_O,
  output logic [7:0] PORT_FIFTEEN_DIGIN_OFF_O,
  // requests
  output logic [1:0] XFER_REQ_O,
  output logic [2:0] EVT_O
);
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic [31:0] timing;
    logic [31:0] prio;
    logic [31:0] par_sel;
    logic [31:0] limits;
    logic [31:0] wfr;
    logic [31:0] evt_en;
    logic [31:0] digin;
    logic [23:0] par_pend;
    logic q_run;
    logic [3:0][4:0] q_ent;
    logic [2:0] q_cnt;
    logic ins_pend;
    logic [4:0] ins_ch;
    adc_seq_pkg::state_type st;
    logic [7:0] cnt;
    logic [3:0] bit_i;
    logic [1:0] act;
    logic [4:0] ch;
    logic [1:0] src;
    logic [1:0][2:0] tgt;
    logic [1:0][9:0] code;
    logic [1:0][7:0][15:0] res;
    logic [1:0][7:0] rv;
    logic [1:0][2:0] wptr;
    logic [2:0] emux;
    logic [1:0] xfer;
    logic [2:0] evt;
    logic stall;
    logic [11:0] clen;
  } seq_type;

  seq_type s_q;
  seq_type s_d;

  function automatic logic [4:0] low_idx(input logic [23:0] m);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 23; i >= 0; i--) begin
      if (m[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // pins seen as digital inputs unless disconnected
  logic [23:0] pin_vis;
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi++) begin : g_pin
      assign pin_vis[gi] = PIN_I[gi] & ~s_q.digin[gi];
    end
  endgenerate

  // arbitration among pending sources
  logic ci, cq, cp, have, blocked;
  logic [1:0] pp, pq, pi, win_src;
  logic [4:0] win_ch;
  logic [1:0] win_act;
  logic [1:0][2:0] win_tgt;
  assign pp = s_q.prio[adc_seq_pkg::PRIO_PAR +: 2];
  assign pq = s_q.prio[adc_seq_pkg::PRIO_QUE +: 2];
  assign pi = s_q.prio[adc_seq_pkg::PRIO_INS +: 2];
  assign ci = s_q.ins_pend;
  assign cq = s_q.q_run && (s_q.q_cnt != 3'h0);
  assign cp = |s_q.par_pend;
  assign have = ci | cq | cp;
  assign win_src = (ci && (!cq || pi >= pq) && (!cp || pi >= pp)) ? adc_seq_pkg::SRC_INS :
                   (cq && (!cp || pq >= pp)) ? adc_seq_pkg::SRC_QUE : adc_seq_pkg::SRC_PAR;
  assign win_ch = (win_src == adc_seq_pkg::SRC_INS) ? s_q.ins_ch :
                  (win_src == adc_seq_pkg::SRC_QUE) ? s_q.q_ent[0] :
                  low_idx(s_q.par_pend);
  assign win_act = win_ch[4] ? 2'b10 : (s_q.ctrl[adc_seq_pkg::CTRL_SYNC] ? 2'b11 : 2'b01);
  assign win_tgt[0] = s_q.ctrl[adc_seq_pkg::CTRL_CHAIN] ? s_q.wptr[0] : win_ch[2:0];
  assign win_tgt[1] = s_q.ctrl[adc_seq_pkg::CTRL_CHAIN] ? s_q.wptr[1] : win_ch[2:0];
  assign blocked = (win_act[0] && s_q.wfr[{2'b00, win_tgt[0]}] && s_q.rv[0][win_tgt[0]]) ||
                   (win_act[1] && s_q.wfr[{2'b01, win_tgt[1]}] && s_q.rv[1][win_tgt[1]]);

  always_comb begin
    logic [1:0][9:0] rslt;
    logic [9:0] v;
    logic [2:0] ix;
    logic last;
    logic [7:0] wa;
    rslt = s_q.code;
    v = 10'h000;
    ix = 3'h0;
    last = 1'b0;
    wa = {s_q.aw_addr[7:2], 2'b00};
    s_d = s_q;
    s_d.xfer = 2'b00;
    s_d.evt = 3'h0;
    // cycles spent in the bit phase, watched by the length checks
    s_d.clen = (s_q.st == adc_seq_pkg::ST_CONV) ? s_q.clen + 12'h001 : 12'h000;
    // read channel; a read of a result clears its valid flag
    if (s_q.rvalid && RREADY_I) begin
      s_d.rvalid = 1'b0;
    end
    if (ARVALID_I && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = adc_seq_pkg::RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      if (ARADDR_I[7:6] == adc_seq_pkg::RES_REGION) begin
        s_d.rdata = {16'h0000, s_q.res[ARADDR_I[5]][ARADDR_I[4:2]]};
        s_d.rv[ARADDR_I[5]][ARADDR_I[4:2]] = 1'b0;
      end else begin
        case ({ARADDR_I[7:2], 2'b00})
          adc_seq_pkg::ADDR_CTRL: s_d.rdata = s_q.ctrl;
          adc_seq_pkg::ADDR_TIMING: s_d.rdata = s_q.timing;
          adc_seq_pkg::ADDR_PRIO: s_d.rdata = s_q.prio;
          adc_seq_pkg::ADDR_PAR_SEL: s_d.rdata = s_q.par_sel;
          adc_seq_pkg::ADDR_START: s_d.rdata = {8'h00, s_q.par_pend};
          adc_seq_pkg::ADDR_QUEUE: s_d.rdata = {29'h0, s_q.q_cnt};
          adc_seq_pkg::ADDR_INSERT: s_d.rdata = {26'h0, s_q.ins_pend, s_q.ins_ch};
          adc_seq_pkg::ADDR_LIMITS: s_d.rdata = s_q.limits;
          adc_seq_pkg::ADDR_WFR: s_d.rdata = s_q.wfr;
          adc_seq_pkg::ADDR_EVT_EN: s_d.rdata = s_q.evt_en;
          adc_seq_pkg::ADDR_DIGIN_OFF: s_d.rdata = s_q.digin;
          adc_seq_pkg::ADDR_STATUS: s_d.rdata = {8'h00, s_q.rv[1], s_q.rv[0], 2'b00,
              s_q.ins_pend, s_q.q_cnt, s_q.stall, s_q.st != adc_seq_pkg::ST_IDLE};
          adc_seq_pkg::ADDR_PIN: s_d.rdata = {8'h00, pin_vis};
          default: s_d.rresp = adc_seq_pkg::RESP_SLVERR;
        endcase
      end
    end
    // conversion engine
    case (s_q.st)
      adc_seq_pkg::ST_IDLE: begin
        s_d.stall = have && blocked;
        if (have && !blocked) begin
          s_d.st = adc_seq_pkg::ST_SAMPLE;
          s_d.cnt = s_q.timing[adc_seq_pkg::TIM_SAMPLE +: 8];
          s_d.ch = win_ch;
          s_d.src = win_src;
          s_d.act = win_act;
          s_d.tgt = win_tgt;
          s_d.code = '0;
          s_d.bit_i = adc_seq_pkg::BIT_TOP;
          case (win_src)
            adc_seq_pkg::SRC_INS: s_d.ins_pend = 1'b0;
            adc_seq_pkg::SRC_QUE: begin
              s_d.q_ent = {5'h00, s_q.q_ent[3:1]};
              s_d.q_cnt = s_q.q_cnt - 3'h1;
              s_d.q_run = (s_q.q_cnt != 3'h1);
            end
            default: s_d.par_pend[win_ch] = 1'b0;
          endcase
        end
      end
      adc_seq_pkg::ST_SAMPLE: begin
        if (s_q.cnt == 8'h00) begin
          s_d.st = adc_seq_pkg::ST_CONV;
          s_d.cnt = s_q.timing[adc_seq_pkg::TIM_BIT +: 8];
          for (int k = 0; k < 2; k++) begin
            s_d.code[k] = s_q.act[k] ? 10'h200 : 10'h000;
          end
        end else begin
          s_d.cnt = s_q.cnt - 8'h01;
        end
      end
      adc_seq_pkg::ST_CONV: begin
        if (s_q.cnt != 8'h00) begin
          s_d.cnt = s_q.cnt - 8'h01;
        end else begin
          // comparator low means the trial level is above the input
          for (int k = 0; k < 2; k++) begin
            if (!CMP_I[k]) begin
              rslt[k][s_q.bit_i] = 1'b0;
            end
          end
          last = s_q.bit_i == (s_q.ctrl[adc_seq_pkg::CTRL_MODE8] ?
                 adc_seq_pkg::BIT_LAST8 : adc_seq_pkg::BIT_LAST10);
          if (!last) begin
            s_d.bit_i = s_q.bit_i - 4'h1;
            s_d.cnt = s_q.timing[adc_seq_pkg::TIM_BIT +: 8];
            for (int k = 0; k < 2; k++) begin
              s_d.code[k] = s_q.act[k] ? (rslt[k] | (10'h001 << (s_q.bit_i - 4'h1))) : 10'h000;
            end
          end else begin
            s_d.st = adc_seq_pkg::ST_IDLE;
            s_d.code = rslt;
            for (int k = 0; k < 2; k++) begin
              if (s_q.act[k]) begin
                v = rslt[k];
                ix = s_q.tgt[k];
                s_d.res[k][ix] = s_q.ctrl[adc_seq_pkg::CTRL_ACCUM] ?
                                 s_q.res[k][ix] + {6'h00, v} : {6'h00, v};
                s_d.rv[k][ix] = 1'b1;
                if (s_q.ctrl[adc_seq_pkg::CTRL_CHAIN]) begin
                  s_d.wptr[k] = s_q.wptr[k] + 3'h1;
                end
                s_d.xfer[k] = 1'b1;
                if (v < s_q.limits[adc_seq_pkg::LIM_LO +: 10] ||
                    v > s_q.limits[adc_seq_pkg::LIM_HI +: 10]) begin
                  s_d.evt[adc_seq_pkg::EVT_LIMIT] = s_q.evt_en[adc_seq_pkg::EVT_LIMIT];
                end
              end
            end
            s_d.evt[adc_seq_pkg::EVT_DONE] = s_q.evt_en[adc_seq_pkg::EVT_DONE];
            if (s_q.src == adc_seq_pkg::SRC_PAR && s_q.par_pend == 24'h0) begin
              s_d.evt[adc_seq_pkg::EVT_SEQ] = s_q.evt_en[adc_seq_pkg::EVT_SEQ];
            end
            if (s_q.ctrl[adc_seq_pkg::CTRL_EMUX_EN]) begin
              s_d.emux = (s_q.emux == s_q.ctrl[adc_seq_pkg::CTRL_EMUX_LEN +: 3]) ? 3'h0 :
                         s_q.emux + 3'h1;
            end
          end
        end
      end
      default: s_d.st = adc_seq_pkg::ST_IDLE;
    endcase
    // write channel: address and data taken in either order
    if (s_q.bvalid && BREADY_I) begin
      s_d.bvalid = 1'b0;
    end
    if (AWVALID_I && !s_q.aw_full) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = AWADDR_I;
    end
    if (WVALID_I && !s_q.w_full) begin
      s_d.w_full = 1'b1;
      s_d.w_data = WDATA_I;
      s_d.w_strb = WSTRB_I;
    end
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = adc_seq_pkg::RESP_OKAY;
      case (wa)
        adc_seq_pkg::ADDR_CTRL: s_d.ctrl = merge(s_q.ctrl, s_q.w_data, s_q.w_strb);
        adc_seq_pkg::ADDR_TIMING: s_d.timing = merge(s_q.timing, s_q.w_data, s_q.w_strb);
        adc_seq_pkg::ADDR_PRIO: s_d.prio = merge(s_q.prio, s_q.w_data, s_q.w_strb);
        adc_seq_pkg::ADDR_PAR_SEL: s_d.par_sel = merge(s_q.par_sel, s_q.w_data, s_q.w_strb);
        adc_seq_pkg::ADDR_START: begin
          if (s_q.w_data[adc_seq_pkg::START_PAR]) begin
            s_d.par_pend = s_d.par_pend | s_q.par_sel[23:0];
          end
          if (s_q.w_data[adc_seq_pkg::START_QUE]) begin
            s_d.q_run = 1'b1;
          end
        end
        adc_seq_pkg::ADDR_QUEUE: begin
          if (s_d.q_cnt != adc_seq_pkg::QUEUE_DEPTH) begin
            s_d.q_ent[s_d.q_cnt[1:0]] = s_q.w_data[4:0];
            s_d.q_cnt = s_d.q_cnt + 3'h1;
          end
        end
        adc_seq_pkg::ADDR_INSERT: begin
          s_d.ins_pend = 1'b1;
          s_d.ins_ch = s_q.w_data[4:0];
        end
        adc_seq_pkg::ADDR_LIMITS: s_d.limits = merge(s_q.limits, s_q.w_data, s_q.w_strb);
        adc_seq_pkg::ADDR_WFR: s_d.wfr = merge(s_q.wfr, s_q.w_data, s_q.w_strb);
        adc_seq_pkg::ADDR_EVT_EN: s_d.evt_en = merge(s_q.evt_en, s_q.w_data, s_q.w_strb);
        adc_seq_pkg::ADDR_DIGIN_OFF: s_d.digin = merge(s_q.digin, s_q.w_data, s_q.w_strb);
        default: s_d.bresp = adc_seq_pkg::RESP_SLVERR;
      endcase
    end
    // hardware triggers
    if (s_q.prio[adc_seq_pkg::TRIG_PAR_EN] && TRIG_I[s_q.prio[adc_seq_pkg::TRIG_PAR +: 2]]) begin
      s_d.par_pend = s_d.par_pend | s_q.par_sel[23:0];
    end
    if (s_q.prio[adc_seq_pkg::TRIG_QUE_EN] && TRIG_I[s_q.prio[adc_seq_pkg::TRIG_QUE +: 2]]) begin
      s_d.q_run = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      s_q <= '0;
      s_q.timing <= adc_seq_pkg::RST_TIMING;
      s_q.limits <= adc_seq_pkg::RST_LIMITS;
      s_q.st <= adc_seq_pkg::ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign AWREADY_O = !s_q.aw_full;
  assign WREADY_O = !s_q.w_full;
  assign BVALID_O = s_q.bvalid;
  assign BRESP_O = s_q.bresp;
  assign ARREADY_O = !s_q.rvalid;
  assign RVALID_O = s_q.rvalid;
  assign RDATA_O = s_q.rdata;
  assign RRESP_O = s_q.rresp;
  assign SAMPLE_O = (s_q.st == adc_seq_pkg::ST_SAMPLE) ? s_q.act : 2'b00;
  assign CH0_SEL_O = s_q.ch[3:0];
  assign CH1_SEL_O = s_q.ch[2:0];
  assign DAC0_O = s_q.code[0];
  assign DAC1_O = s_q.code[1];
  assign EMUX_O = s_q.emux;
  assign PWRDN_O = s_q.ctrl[adc_seq_pkg::CTRL_APD] ?
                   ~((s_q.st != adc_seq_pkg::ST_IDLE) ? s_q.act : 2'b00) : 2'b00;
  assign PORT_FIVE_DIGIN_OFF_O = s_q.digin[15:0];
  assign PORT_FIFTEEN_DIGIN_OFF_O = s_q.digin[23:16];
  assign XFER_REQ_O = s_q.xfer;
  assign EVT_O = s_q.evt;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  sequence s_start;
    s_q.st == adc_seq_pkg::ST_IDLE && s_d.st == adc_seq_pkg::ST_SAMPLE;
  endsequence
  sequence s_done;
    s_q.st == adc_seq_pkg::ST_CONV && s_d.st == adc_seq_pkg::ST_IDLE;
  endsequence
  a_conv_ten_bits: assert property (s_done ##0 !s_q.ctrl[adc_seq_pkg::CTRL_MODE8] |->
    s_q.clen == 12'((12'(s_q.timing[adc_seq_pkg::TIM_BIT +: 8]) + 12'h001) * 12'h00A - 12'h001))
    else $error("full conversion length wrong");
  a_conv_eight_bits: assert property (s_done ##0 s_q.ctrl[adc_seq_pkg::CTRL_MODE8] |->
    s_q.clen == 12'((12'(s_q.timing[adc_seq_pkg::TIM_BIT +: 8]) + 12'h001) * 12'h008 - 12'h001))
    else $error("short conversion length wrong");
  a_low_bits_zero: assert property (s_q.ctrl[adc_seq_pkg::CTRL_MODE8] &&
    s_q.st == adc_seq_pkg::ST_CONV |-> DAC0_O[1:0] == 2'b00) else $error("low bits set");
  a_wfr_no_loss: assert property (s_done ##0 s_q.act[0] && s_q.wfr[{2'b00, s_q.tgt[0]}]
    |-> !s_q.rv[0][s_q.tgt[0]]) else $error("unread result overwritten");
  a_xfer_pulse: assert property (s_done |=> XFER_REQ_O == $past(s_q.act) ##1
    XFER_REQ_O == 2'b00) else $error("transfer request wrong");
  a_par_order: assert property (s_start ##0 s_d.src == adc_seq_pkg::SRC_PAR |=>
    s_q.ch == low_idx($past(s_q.par_pend))) else $error("parallel order wrong");
  a_tie_insert: assert property (s_start ##0 ci && cq && pi == pq && (!cp || pi >= pp)
    |=> s_q.src == adc_seq_pkg::SRC_INS) else $error("tie not resolved to insert");
  a_prio_wins: assert property (s_start ##0 cq && cp && pp > pq |=>
    s_q.src != adc_seq_pkg::SRC_QUE) else $error("lower priority won");
  a_sync_sample: assert property (s_start ##0 s_q.ctrl[adc_seq_pkg::CTRL_SYNC] && !win_ch[4]
    |=> SAMPLE_O == 2'b11) else $error("sync sampling missing");
  a_power_down: assert property (s_q.st == adc_seq_pkg::ST_IDLE &&
    s_q.ctrl[adc_seq_pkg::CTRL_APD] |-> PWRDN_O == 2'b11) else $error("idle not powered down");
  a_axi_bresp: assert property (s_q.aw_full && s_q.w_full && !s_q.bvalid |=> BVALID_O)
    else $error("write response missing");
endmodule
`default_nettype wire

// >>> tb/analog_model.sv
// behavioural analog pins and comparators of both converters
`timescale 1ns/1ps
`default_nettype none
module analog_model (
  // converter side
  input wire logic [3:0] ch0_sel_i,
  input wire logic [2:0] ch1_sel_i,
  input wire logic [9:0] dac0_i,
  input wire logic [9:0] dac1_i,
  // pin levels, ten bits per pin
  input wire logic [239:0] level_i,
  // comparator outputs
  output logic [1:0] cmp_o
);
  logic [9:0] lv0;
  logic [9:0] lv1;
  // 16 pins on the first converter, 8 on the second
  assign lv0 = level_i[ch0_sel_i * 10 +: 10];
  assign lv1 = level_i[(16 + ch1_sel_i) * 10 +: 10];
  assign cmp_o[0] = lv0 >= dac0_i;
  assign cmp_o[1] = lv1 >= dac1_i;
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench of the two-converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic srst;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr, p15_off;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, trig, ch0_sel;
  logic [1:0] bresp, rresp, r, cmp, sample, pwrdn, xfer;
  logic [23:0] pin, m;
  logic [2:0] ch1_sel, emux, evt;
  logic [9:0] dac0, dac1, o;
  logic [15:0] p5_off;
  logic [9:0] lv [24];
  logic [239:0] level;
  logic [3:0] seq_q [$];
  logic [3:0] chs [$];
  logic s_q = 1'b0;
  int fails = 0;
  int total_checks = 0;
  int xcnt = 0;
  int lcnt = 0;
  int dcnt = 0;
  int qcnt = 0;
  int e;

  sar_adc_sequencer u_dut (
    .CLK_I(clk), .SRST_I(srst), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
    .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
    .RREADY_I(rready), .TRIG_I(trig), .CMP_I(cmp), .PIN_I(pin), .SAMPLE_O(sample),
    .CH0_SEL_O(ch0_sel), .CH1_SEL_O(ch1_sel), .DAC0_O(dac0), .DAC1_O(dac1), .EMUX_O(emux),
    .PWRDN_O(pwrdn), .PORT_FIVE_DIGIN_OFF_O(p5_off), .PORT_FIFTEEN_DIGIN_OFF_O(p15_off),
    .XFER_REQ_O(xfer), .EVT_O(evt)
  );
  analog_model u_ana (.ch0_sel_i(ch0_sel), .ch1_sel_i(ch1_sel), .dac0_i(dac0), .dac1_i(dac1),
    .level_i(level), .cmp_o(cmp));

  always #12.5 clk = ~clk;
  always_comb for (int i = 0; i < 24; i++) level[i * 10 +: 10] = lv[i];

  // channel order at each converter 0 sample start, stored results, limit events
  always @(posedge clk) begin
    s_q <= sample[0];
    if (sample[0] && !s_q) seq_q.push_back(ch0_sel);
    if (xfer[0]) xcnt++;
    if (evt[1]) lcnt++;
    if (evt[0]) dcnt++;
    if (evt[2]) qcnt++;
  end

  task automatic end_sim();
    if (fails == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %0t got %h want %h", $time, g, x);
    end
  endtask

  task automatic hang();
    fails++;
    $display("MISMATCH %0t wait ran out", $time);
    end_sim();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit aw;
    bit w;
    int n;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64 && bvalid !== 1'b1; n++) begin
      @(posedge clk);
      if (aw && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wready === 1'b1) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    if (n == 64) hang();
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64 && rvalid !== 1'b1; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    if (n == 64) hang();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    rd(a);
    chk(d, x);
  endtask

  task automatic wait_x(input int n);
    int t;
    t = xcnt + n;
    for (int k = 0; k < 3000; k++) begin
      @(posedge clk);
      if (xcnt >= t) return;
    end
    hang();
  endtask

  task automatic seqchk(input logic [3:0] x [$]);
    chk(32'(seq_q.size()), 32'(x.size()));
    foreach (x[i]) chk({28'h0, seq_q[i]}, {28'h0, x[i]});
    seq_q.delete();
  endtask

  function automatic logic [7:0] ra(input logic [3:0] c);
    return 8'h40 + {3'h0, c[2:0], 2'h0};
  endfunction

  function automatic int nlim(input logic [3:0] c [$]);
    int k;
    k = 0;
    foreach (c[i]) k += int'(lv[c[i]] > 10'h1FF);
    return k;
  endfunction

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    trig = 4'h0;
    srst = 1'b1;
    void'($urandom(32'h34250576));
    foreach (lv[i]) lv[i] = 10'($urandom);
    pin = 24'($urandom);
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rchk(adc_seq_pkg::ADDR_TIMING, adc_seq_pkg::RST_TIMING);
    rchk(adc_seq_pkg::ADDR_LIMITS, adc_seq_pkg::RST_LIMITS);
    rchk(8'h3C, 32'h0);
    chk({30'h0, r}, {30'h0, adc_seq_pkg::RESP_SLVERR});
    wr(8'h40, 32'h1);
    chk({30'h0, r}, {30'h0, adc_seq_pkg::RESP_SLVERR});
    // chained results, parallel set in fixed order
    wr(adc_seq_pkg::ADDR_EVT_EN, 32'h7);
    wr(adc_seq_pkg::ADDR_CTRL, 32'h14);
    wr(adc_seq_pkg::ADDR_PAR_SEL, 32'h24);
    wr(adc_seq_pkg::ADDR_START, 32'h1);
    wait_x(2);
    seqchk('{4'h2, 4'h5});
    rchk(8'h40, {22'h0, lv[2]});
    rchk(8'h44, {22'h0, lv[5]});
    chk({30'h0, pwrdn}, 32'h3);
    // queue order with an inserted channel, upper limit
    wr(adc_seq_pkg::ADDR_CTRL, 32'h10);
    wr(adc_seq_pkg::ADDR_LIMITS, 32'h01FF_0000);
    chs = '{4'h6, 4'hA, 4'h1, 4'h4};
    e = lcnt + nlim(chs);
    foreach (chs[i]) if (i != 1) wr(adc_seq_pkg::ADDR_QUEUE, {28'h0, chs[i]});
    wr(adc_seq_pkg::ADDR_START, 32'h2);
    wr(adc_seq_pkg::ADDR_INSERT, 32'hA);
    wait_x(4);
    seqchk(chs);
    foreach (chs[i]) rchk(ra(chs[i]), {22'h0, lv[chs[i]]});
    chk(32'(lcnt), 32'(e));
    // higher priority parallel source beats the queue
    wr(adc_seq_pkg::ADDR_PRIO, 32'h3);
    wr(adc_seq_pkg::ADDR_QUEUE, 32'h5);
    wr(adc_seq_pkg::ADDR_PAR_SEL, 32'h88);
    wr(adc_seq_pkg::ADDR_START, 32'h3);
    wait_x(3);
    seqchk('{4'h3, 4'h7, 4'h5});
    // trigger start, 8-bit mode, both converters together
    wr(adc_seq_pkg::ADDR_PRIO, 32'h1000);
    wr(adc_seq_pkg::ADDR_CTRL, 32'h13);
    wr(adc_seq_pkg::ADDR_PAR_SEL, 32'h8);
    trig <= 4'h1;
    @(posedge clk);
    trig <= 4'h0;
    wait_x(1);
    seqchk('{4'h3});
    rchk(8'h4C, {22'h0, lv[3][9:2], 2'h0});
    rchk(8'h6C, {22'h0, lv[19][9:2], 2'h0});
    // second result waits until the first is read
    wr(adc_seq_pkg::ADDR_PRIO, 32'h0);
    wr(adc_seq_pkg::ADDR_CTRL, 32'h0);
    wr(adc_seq_pkg::ADDR_WFR, 32'h8);
    wr(adc_seq_pkg::ADDR_START, 32'h1);
    wait_x(1);
    o = lv[3];
    lv[3] <= ~o;
    wr(adc_seq_pkg::ADDR_START, 32'h1);
    rd(adc_seq_pkg::ADDR_STATUS);
    chk({31'h0, d[1]}, 32'h1);
    rchk(8'h4C, {22'h0, o});
    wait_x(1);
    rchk(8'h4C, {22'h0, ~o});
    // digital input disable per pin
    m = 24'($urandom);
    wr(adc_seq_pkg::ADDR_DIGIN_OFF, {8'h0, m});
    chk({8'h0, p15_off, p5_off}, {8'h0, m});
    rchk(adc_seq_pkg::ADDR_PIN, {8'h0, pin & ~m});
    // external mux steps through 0..2, one register accumulates
    wr(adc_seq_pkg::ADDR_CTRL, 32'hA8);
    chk({30'h0, r}, {30'h0, adc_seq_pkg::RESP_OKAY});
    for (int i = 1; i < 5; i++) begin
      wr(adc_seq_pkg::ADDR_START, 32'h1);
      wait_x(1);
      chk({29'h0, emux}, 32'(i % 3));
      rchk(8'h4C, 32'({6'h0, ~o}) * (i + 1));
    end
    chk(32'(xcnt), 32'h10);
    chk(32'(dcnt), 32'h10);
    chk(32'(qcnt), 32'h9);
    end_sim();
  end
endmodule
`default_nettype wire
